// >>> rtl/msr_pkg.sv
`default_nettype none

package msr_pkg;

	// Widths of the register fields.
	localparam int unsigned MSR_AW  = 8;
	localparam int unsigned MSR_DW  = 32;
	localparam int unsigned MSR_VW  = 20;
	localparam int unsigned MSR_OPW = 8;
	localparam int unsigned MSR_KW  = 7;
	localparam int unsigned MSR_CW  = 10;
	localparam int unsigned MSR_PW  = 16;

	// Register byte offsets on the bus.
	localparam logic [7:0] MSR_ADR_KEY      = 8'h00;
	localparam logic [7:0] MSR_ADR_LIM_CUR  = 8'h04;
	localparam logic [7:0] MSR_ADR_LIM_RATE = 8'h08;
	localparam logic [7:0] MSR_ADR_LOCK     = 8'h0C;
	localparam logic [7:0] MSR_ADR_WATER    = 8'h10;
	localparam logic [7:0] MSR_ADR_IFACE    = 8'h14;
	localparam logic [7:0] MSR_ADR_OP_COND  = 8'h18;
	localparam logic [7:0] MSR_ADR_OP_MASK  = 8'h1C;
	localparam logic [7:0] MSR_ADR_OP_EVENT = 8'h20;
	localparam logic [7:0] MSR_ADR_RATE     = 8'h24;
	localparam logic [7:0] MSR_ADR_CUR_SET  = 8'h28;

	// Field position of the lockout code inside the lock register.
	localparam int unsigned MSR_LOCK_CODE_LSB = 16;

	// Value ranges; one LSB is 0.1 mA or 0.1 mA/s.
	localparam logic [19:0] MSR_CUR_MAX       = 20'hA_B248;
	localparam logic [19:0] MSR_RATE_MIN      = 20'h0_0001;
	localparam logic [19:0] MSR_RATE_MAX      = 20'h7_A120;
	localparam logic [9:0]  MSR_LOCK_CODE_MAX = 10'h3E7;

	// Reset values, and the key code left by a read clear.
	localparam logic [6:0]  MSR_KEY_POWERUP = 7'h01;
	localparam logic [6:0]  MSR_KEY_NONE    = 7'h00;
	localparam logic [19:0] MSR_RATE_RST    = 20'h0_2710;
	localparam logic [19:0] MSR_CUR_RST     = 20'h0_0000;
	localparam logic [9:0]  MSR_CODE_RST    = 10'h000;
	localparam logic [7:0]  MSR_OP_RST      = 8'h00;

	// Output power thresholds for automatic coil water, in watts.
	localparam logic [15:0] MSR_WATER_ON_W  = 16'h0064;
	localparam logic [15:0] MSR_WATER_OFF_W = 16'h0032;

	typedef enum logic [1:0] {
		MSR_LOCK_NONE   = 2'b00,
		MSR_LOCK_ALL    = 2'b01,
		MSR_LOCK_LIMITS = 2'b10
	} msr_lock_t;

	typedef enum logic [1:0] {
		MSR_WTR_OFF  = 2'b00,
		MSR_WTR_ON   = 2'b01,
		MSR_WTR_AUTO = 2'b10,
		MSR_WTR_DIS  = 2'b11
	} msr_water_t;

	typedef enum logic [1:0] {
		MSR_IF_LOCAL  = 2'b00,
		MSR_IF_REMOTE = 2'b01,
		MSR_IF_RLLO   = 2'b10
	} msr_iface_t;

	typedef enum logic [1:0] {
		MSR_PNL_CUR      = 2'b00,
		MSR_PNL_RATE     = 2'b01,
		MSR_PNL_LIM_CUR  = 2'b10,
		MSR_PNL_LIM_RATE = 2'b11
	} msr_panel_t;

	typedef enum logic [0:0] {
		MSR_BUS_IDLE = 1'b0,
		MSR_BUS_ACK  = 1'b1
	} msr_bus_t;

endpackage

`default_nettype wire

// >>> rtl/msr_sync.sv
`timescale 1ns/100ps
`default_nettype none

module msr_sync #(
	parameter int unsigned W = 8
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Asynchronous level in, synchronised level out.
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} msr_sync_st_t;

	msr_sync_st_t st_r;
	msr_sync_st_t st_nxt;

	// Two flip-flop chain; only the second stage is read outside.
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.s2;

endmodule

`default_nettype wire

// >>> rtl/msr_key_latch.sv
`timescale 1ns/100ps
`default_nettype none

module msr_key_latch
	import msr_pkg::*;
(
	// Clock and reset.
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Key press event and read-clear request.
	input  wire logic                     key_stb_i,
	input  wire logic [msr_pkg::MSR_KW-1:0] key_code_i,
	input  wire logic                     clr_i,
	// Held key code.
	output logic      [msr_pkg::MSR_KW-1:0] code_o
);

	typedef struct packed {
		logic [MSR_KW-1:0] code;
	} msr_key_st_t;

	msr_key_st_t st_r;
	msr_key_st_t st_nxt;

	// A key press in the clear cycle wins over the clear.
	always_comb begin
		st_nxt = st_r;
		if (key_stb_i) begin
			st_nxt.code = key_code_i;
		end else if (clr_i) begin
			st_nxt.code = MSR_KEY_NONE;
		end
	end

	// Power-up value reads as the start code.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.code <= MSR_KEY_POWERUP;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign code_o = st_r.code;

endmodule

`default_nettype wire

// >>> rtl/msr_remote.sv
// Functional notes
// - Key code register returns the last key pressed since the previous read.
// - After reset the first key code read returns 01.
// - With no key since the last read, the key code read returns 00.
// - Current limit accepts 0 to 70.1000 A; writes above the span are ignored.
// - Ramp rate limit accepts 0.0001 to 50.000 A/s.
// - Later current and rate settings are clamped to the stored limits.
// - Lock state 1 locks all panel entry, 2 only limits, 0 unlocks.
// - Lock command carries a code 000 to 999, stored with the state.
// - Panel entries covered by the active lock state are rejected.
// - Coil water mode: 0 off, 1 on, 2 automatic, 3 disabled.
// - Automatic water mode drives the valve from computed output power.
// - Interface mode: 0 local, 1 remote, 2 remote with local lockout.
// - Condition query returns the weighted sum of present condition bits.
// - Enable mask selects which condition bits may set the summary bit.
// - Event register latches each condition bit and holds it until read.
// - Reading the event register returns its value and clears it.
// - Ramp rate for a new setpoint lies within 0.0001 to 50.000 A/s.
// - One stored ramp rate serves rising and falling current alike.
// - A written ramp rate is clamped to the stored rate limit.
`timescale 1ns/100ps
`default_nettype none

module msr_remote
	import msr_pkg::*;
(
	// Clock and reset.
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// Wishbone classic slave.
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [msr_pkg::MSR_AW-1:0]  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [msr_pkg::MSR_DW-1:0]  wb_dat_i,
	output logic      [msr_pkg::MSR_DW-1:0]  wb_dat_o,
	output logic                             wb_ack_o,
	// Front panel keypad and data entry.
	input  wire logic                        key_stb_i,
	input  wire logic [msr_pkg::MSR_KW-1:0]  key_code_i,
	input  wire logic                        panel_stb_i,
	input  wire msr_pkg::msr_panel_t         panel_sel_i,
	input  wire logic [msr_pkg::MSR_VW-1:0]  panel_val_i,
	output logic                             panel_rej_o,
	// Supply plant.
	input  wire logic [msr_pkg::MSR_OPW-1:0] op_cond_i,
	input  wire logic [msr_pkg::MSR_PW-1:0]  out_power_i,
	output logic      [msr_pkg::MSR_VW-1:0]  cur_set_o,
	output logic      [msr_pkg::MSR_VW-1:0]  ramp_rate_o,
	output logic                             water_valve_o,
	output logic                             remote_o,
	output logic                             local_lockout_o,
	output logic                             op_summary_o
);

	typedef struct packed {
		msr_bus_t          bus;
		logic [MSR_DW-1:0] dat;
		logic [MSR_VW-1:0] lim_cur;
		logic [MSR_VW-1:0] lim_rate;
		logic [MSR_VW-1:0] rate;
		logic [MSR_VW-1:0] cur_set;
		msr_lock_t         lock_state;
		logic [MSR_CW-1:0] lock_code;
		msr_water_t        water;
		msr_iface_t        iface;
		logic [MSR_OPW-1:0] op_mask;
		logic [MSR_OPW-1:0] op_event;
		logic              valve;
		logic              rej;
		logic              summary;
		logic              remote;
		logic              lockout;
	} msr_state_t;

	msr_state_t         st_r;
	msr_state_t         st_nxt;
	logic [MSR_OPW-1:0] op_cond_s;
	logic [MSR_KW-1:0]  key_code;
	logic               key_clr;
	logic               bus_req;
	logic               wr_now;
	logic [MSR_DW-1:0]  wr_word;
	logic               op_clr;

	// Smaller of a value and its limit.
	function automatic logic [MSR_VW-1:0] msr_clamp(input logic [MSR_VW-1:0] v,
		input logic [MSR_VW-1:0] lim);
		msr_clamp = (v > lim) ? lim : v;
	endfunction

	// True when a rate lies inside the legal rate span.
	function automatic logic msr_rate_ok(input logic [MSR_VW-1:0] v);
		msr_rate_ok = (v >= MSR_RATE_MIN) && (v <= MSR_RATE_MAX);
	endfunction

	// Byte-lane merge of a write into the old register word.
	function automatic logic [MSR_DW-1:0] msr_merge(input logic [MSR_DW-1:0] old_w,
		input logic [MSR_DW-1:0] new_w, input logic [3:0] sel);
		logic [MSR_DW-1:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		msr_merge = res;
	endfunction

	// Read image of a register, in the same layout a write uses.
	function automatic logic [MSR_DW-1:0] msr_read(input msr_state_t s,
		input logic [MSR_AW-1:0] adr, input logic [MSR_OPW-1:0] cond,
		input logic [MSR_KW-1:0] key);
		logic [MSR_DW-1:0] d;
		d = '0;
		case (adr)
			MSR_ADR_KEY:      d[MSR_KW-1:0] = key;
			MSR_ADR_LIM_CUR:  d[MSR_VW-1:0] = s.lim_cur;
			MSR_ADR_LIM_RATE: d[MSR_VW-1:0] = s.lim_rate;
			MSR_ADR_LOCK: begin
				d[1:0] = s.lock_state;
				d[MSR_LOCK_CODE_LSB +: MSR_CW] = s.lock_code;
			end
			MSR_ADR_WATER:    d[1:0] = s.water;
			MSR_ADR_IFACE:    d[1:0] = s.iface;
			MSR_ADR_OP_COND:  d[MSR_OPW-1:0] = cond;
			MSR_ADR_OP_MASK:  d[MSR_OPW-1:0] = s.op_mask;
			MSR_ADR_OP_EVENT: d[MSR_OPW-1:0] = s.op_event;
			MSR_ADR_RATE:     d[MSR_VW-1:0] = s.rate;
			MSR_ADR_CUR_SET:  d[MSR_VW-1:0] = s.cur_set;
			default:          d = '0;
		endcase
		msr_read = d;
	endfunction

	// Condition inputs come from the plant and cross into this clock.
	msr_sync #(
		.W (MSR_OPW)
	) u_cond_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (op_cond_i),
		.q_o   (op_cond_s)
	);

	// Last key pressed, cleared when software reads it.
	msr_key_latch u_key (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.key_stb_i  (key_stb_i),
		.key_code_i (key_code_i),
		.clr_i      (key_clr),
		.code_o     (key_code)
	);

	// Bus request decode; reads capture and clear at the same edge.
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign wr_now  = bus_req && wb_we_i && (st_r.bus == MSR_BUS_ACK);
	assign key_clr = bus_req && !wb_we_i && (st_r.bus == MSR_BUS_IDLE)
		&& (wb_adr_i == MSR_ADR_KEY);
	assign op_clr  = bus_req && !wb_we_i && (st_r.bus == MSR_BUS_IDLE)
		&& (wb_adr_i == MSR_ADR_OP_EVENT);
	assign wr_word = msr_merge(msr_read(st_r, wb_adr_i, op_cond_s, key_code), wb_dat_i,
		wb_sel_i);

	// Next state of the whole block.
	always_comb begin
		logic [MSR_VW-1:0] v;
		logic [MSR_CW-1:0] code;
		logic              lock_hit;
		v        = wr_word[MSR_VW-1:0];
		code     = wr_word[MSR_LOCK_CODE_LSB +: MSR_CW];
		lock_hit = 1'b0;
		st_nxt   = st_r;
		st_nxt.rej = 1'b0;

		// Bus handshake: ack one cycle after the request, then drop.
		case (st_r.bus)
			MSR_BUS_IDLE: begin
				if (bus_req) begin
					st_nxt.bus = MSR_BUS_ACK;
					st_nxt.dat = wb_we_i ? '0 : msr_read(st_r, wb_adr_i, op_cond_s, key_code);
				end
			end
			MSR_BUS_ACK: begin
				st_nxt.bus = MSR_BUS_IDLE;
				st_nxt.dat = '0;
			end
			default: begin
				st_nxt.bus = MSR_BUS_IDLE;
			end
		endcase

		// Register writes take effect at the edge that ends the access.
		if (wr_now) begin
			case (wb_adr_i)
				MSR_ADR_LIM_CUR: begin
					if (v <= MSR_CUR_MAX) begin
						st_nxt.lim_cur = v;
						st_nxt.cur_set = msr_clamp(st_r.cur_set, v);
					end
				end
				MSR_ADR_LIM_RATE: begin
					if (msr_rate_ok(v)) begin
						st_nxt.lim_rate = v;
						st_nxt.rate     = msr_clamp(st_r.rate, v);
					end
				end
				MSR_ADR_LOCK: begin
					if ((wr_word[1:0] != 2'b11) && (code <= MSR_LOCK_CODE_MAX)) begin
						st_nxt.lock_state = msr_lock_t'(wr_word[1:0]);
						st_nxt.lock_code  = code;
					end
				end
				MSR_ADR_WATER: begin
					st_nxt.water = msr_water_t'(wr_word[1:0]);
				end
				MSR_ADR_IFACE: begin
					if (wr_word[1:0] != 2'b11) begin
						st_nxt.iface = msr_iface_t'(wr_word[1:0]);
					end
				end
				MSR_ADR_OP_MASK: begin
					st_nxt.op_mask = wr_word[MSR_OPW-1:0];
				end
				MSR_ADR_RATE: begin
					if (msr_rate_ok(v)) begin
						st_nxt.rate = msr_clamp(v, st_r.lim_rate);
					end
				end
				default: begin
					st_nxt.rate = st_r.rate;
				end
			endcase
		end

		// Front panel entry, gated by keypad lock and local lockout.
		if (panel_stb_i) begin
			case (panel_sel_i)
				MSR_PNL_LIM_CUR, MSR_PNL_LIM_RATE: begin
					lock_hit = (st_r.lock_state != MSR_LOCK_NONE);
				end
				default: begin
					lock_hit = (st_r.lock_state == MSR_LOCK_ALL);
				end
			endcase
			if (lock_hit || (st_r.iface == MSR_IF_RLLO)) begin
				st_nxt.rej = 1'b1;
			end else begin
				case (panel_sel_i)
					MSR_PNL_CUR: begin
						if (panel_val_i <= MSR_CUR_MAX) begin
							st_nxt.cur_set = msr_clamp(panel_val_i, st_r.lim_cur);
						end else begin
							st_nxt.rej = 1'b1;
						end
					end
					MSR_PNL_RATE: begin
						if (msr_rate_ok(panel_val_i)) begin
							st_nxt.rate = msr_clamp(panel_val_i, st_r.lim_rate);
						end else begin
							st_nxt.rej = 1'b1;
						end
					end
					MSR_PNL_LIM_CUR: begin
						if (panel_val_i <= MSR_CUR_MAX) begin
							st_nxt.lim_cur = panel_val_i;
							st_nxt.cur_set = msr_clamp(st_r.cur_set, panel_val_i);
						end else begin
							st_nxt.rej = 1'b1;
						end
					end
					MSR_PNL_LIM_RATE: begin
						if (msr_rate_ok(panel_val_i)) begin
							st_nxt.lim_rate = panel_val_i;
							st_nxt.rate     = msr_clamp(st_r.rate, panel_val_i);
						end else begin
							st_nxt.rej = 1'b1;
						end
					end
					default: begin
						st_nxt.rej = 1'b1;
					end
				endcase
			end
		end

		// Events latch while their condition stands; a set wins over the read clear.
		st_nxt.op_event = (op_clr ? MSR_OP_RST : st_r.op_event) | op_cond_s;

		// Summary bit follows latched events that the mask enables.
		st_nxt.summary = |(st_nxt.op_event & st_nxt.op_mask);

		// Interface flags are decoded ahead so that the outputs leave a flip-flop.
		st_nxt.remote  = (st_nxt.iface != MSR_IF_LOCAL);
		st_nxt.lockout = (st_nxt.iface == MSR_IF_RLLO);

		// Coil water valve per mode, with hysteresis in automatic mode.
		case (st_r.water)
			MSR_WTR_OFF:  st_nxt.valve = 1'b0;
			MSR_WTR_ON:   st_nxt.valve = 1'b1;
			MSR_WTR_AUTO: begin
				if (out_power_i >= MSR_WATER_ON_W) begin
					st_nxt.valve = 1'b1;
				end else if (out_power_i <= MSR_WATER_OFF_W) begin
					st_nxt.valve = 1'b0;
				end
			end
			MSR_WTR_DIS:  st_nxt.valve = 1'b0;
			default:      st_nxt.valve = 1'b0;
		endcase
	end

	// State register with reset values.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.bus        <= MSR_BUS_IDLE;
			st_r.dat        <= '0;
			st_r.lim_cur    <= MSR_CUR_MAX;
			st_r.lim_rate   <= MSR_RATE_MAX;
			st_r.rate       <= MSR_RATE_RST;
			st_r.cur_set    <= MSR_CUR_RST;
			st_r.lock_state <= MSR_LOCK_NONE;
			st_r.lock_code  <= MSR_CODE_RST;
			st_r.water      <= MSR_WTR_OFF;
			st_r.iface      <= MSR_IF_LOCAL;
			st_r.op_mask    <= MSR_OP_RST;
			st_r.op_event   <= MSR_OP_RST;
			st_r.valve      <= 1'b0;
			st_r.rej        <= 1'b0;
			st_r.summary    <= 1'b0;
			st_r.remote     <= 1'b0;
			st_r.lockout    <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register.
	assign wb_ack_o        = (st_r.bus == MSR_BUS_ACK);
	assign wb_dat_o        = st_r.dat;
	assign panel_rej_o     = st_r.rej;
	assign cur_set_o       = st_r.cur_set;
	assign ramp_rate_o     = st_r.rate;
	assign water_valve_o   = st_r.valve;
	assign remote_o        = st_r.remote;
	assign local_lockout_o = st_r.lockout;
	assign op_summary_o    = st_r.summary;

endmodule

`default_nettype wire

// >>> bench/msr_remote_checker.sv
`timescale 1ns/100ps
`default_nettype none

module msr_remote_checker
	import msr_pkg::*;
(
	// Clock and reset.
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Bus signals.
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [msr_pkg::MSR_DW-1:0] wb_dat_o,
	input  wire logic                       wb_ack_o,
	// Panel and plant signals.
	input  wire logic                       panel_stb_i,
	input  wire logic                       panel_rej_o,
	input  wire logic [msr_pkg::MSR_VW-1:0] cur_set_o,
	input  wire logic [msr_pkg::MSR_VW-1:0] ramp_rate_o,
	input  wire logic                       remote_o,
	input  wire logic                       local_lockout_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A fresh request, and the one-cycle answer it must get.
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence

	property p_ack_once; s_req |=> s_ans; endproperty
	a_ack_once: assert property (p_ack_once) else $error("bus answer not one cycle");
	property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
	property p_lockout; local_lockout_o |-> remote_o; endproperty
	a_lockout: assert property (p_lockout) else $error("lockout without remote");
	property p_rej_lockout; panel_stb_i && local_lockout_o |=> panel_rej_o; endproperty
	a_rej_lockout: assert property (p_rej_lockout) else $error("entry taken in lockout");
	property p_rej_cause; panel_rej_o |-> $past(panel_stb_i); endproperty
	a_rej_cause: assert property (p_rej_cause) else $error("reject without entry");
	property p_cur_max; cur_set_o <= MSR_CUR_MAX; endproperty
	a_cur_max: assert property (p_cur_max) else $error("setpoint above span");
	property p_rate_span; ramp_rate_o >= MSR_RATE_MIN && ramp_rate_o <= MSR_RATE_MAX; endproperty
	a_rate_span: assert property (p_rate_span) else $error("ramp rate outside span");
	// Stored settings move only after a bus write or a panel entry.
	property p_rate_cause;
		$changed(ramp_rate_o) && !$past(rst_i) |-> $past(wb_ack_o && wb_we_i) || $past(panel_stb_i);
	endproperty
	a_rate_cause: assert property (p_rate_cause) else $error("ramp rate moved alone");
	property p_cur_cause;
		$changed(cur_set_o) && !$past(rst_i) |-> $past(wb_ack_o && wb_we_i) || $past(panel_stb_i);
	endproperty
	a_cur_cause: assert property (p_cur_cause) else $error("setpoint moved alone");
endmodule

bind msr_remote msr_remote_checker u_chk (.*);

`default_nettype wire

// >>> bench/msr_host.sv
`timescale 1ns/100ps
`default_nettype none

module msr_host
	import msr_pkg::*;
(
	// Clock.
	input  wire logic                       clk_i,
	// Bus master side.
	output logic                            wb_cyc_o,
	output logic                            wb_stb_o,
	output logic                            wb_we_o,
	output logic      [msr_pkg::MSR_AW-1:0] wb_adr_o,
	output logic      [3:0]                 wb_sel_o,
	output logic      [msr_pkg::MSR_DW-1:0] wb_dat_o,
	input  wire logic [msr_pkg::MSR_DW-1:0] wb_dat_i,
	input  wire logic                       wb_ack_i
);
	// Idle bus at time zero.
	initial begin
		wb_cyc_o = 1'h0;
		wb_stb_o = 1'h0;
		wb_we_o  = 1'h0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0000_0000;
	end

	// One classic cycle; the request stands until the edge that sees ack.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc_o <= 1'h1;
		wb_stb_o <= 1'h1;
		wb_we_o  <= w;
		wb_adr_o <= a;
		wb_sel_o <= 4'hF;
		wb_dat_o <= d;
		do begin
			@(posedge clk_i);
			#1;
		end while (wb_ack_i !== 1'h1);
		r = wb_dat_i;
		@(posedge clk_i);
		wb_cyc_o <= 1'h0;
		wb_stb_o <= 1'h0;
		wb_we_o  <= 1'h0;
		wb_dat_o <= ~d; // Released data never repeats the last word.
	endtask
endmodule

`default_nettype wire

// >>> bench/tb_msr_remote.sv
`timescale 1ns/100ps
`default_nettype none

module tb_msr_remote;
	import msr_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, ack, kstb, pstb, prej;
	logic        valve, remote, lockout, summary;
	logic [7:0]  adr, cond;
	logic [3:0]  sel;
	logic [31:0] wd, rd;
	logic [6:0]  kcode;
	logic [19:0] pval, cur, rate;
	logic [15:0] pwr;
	msr_panel_t  psel;
	int          mismatches, checks;

	msr_remote dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.key_stb_i(kstb), .key_code_i(kcode), .panel_stb_i(pstb), .panel_sel_i(psel),
		.panel_val_i(pval), .panel_rej_o(prej), .op_cond_i(cond), .out_power_i(pwr),
		.cur_set_o(cur), .ramp_rate_o(rate), .water_valve_o(valve), .remote_o(remote),
		.local_lockout_o(lockout), .op_summary_o(summary));
	msr_host host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
		.wb_sel_o(sel), .wb_dat_o(wd), .wb_dat_i(rd), .wb_ack_i(ack));

	// Print the verdict and stop.
	task automatic end_sim();
		if (mismatches == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		host.xfer(1'h1, a, d, v);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		host.xfer(1'h0, a, 32'h0000_0000, v);
		chk($sformatf("register %h", a), v, e);
	endtask

	// One panel entry; the reject pulse is looked at in its only cycle.
	task automatic pnl(input msr_panel_t s, input logic [19:0] v, input logic e);
		@(posedge clk_i);
		pstb <= 1'h1;
		psel <= s;
		pval <= v;
		@(posedge clk_i);
		pstb <= 1'h0;
		#1 chk("panel reject", 32'(prej), 32'(e));
	endtask

	task automatic key(input logic [6:0] c);
		@(posedge clk_i);
		kstb  <= 1'h1;
		kcode <= c;
		@(posedge clk_i);
		kstb  <= 1'h0;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Clock at 250 MHz.
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	// Main sequence.
	initial begin
		rst_i = 1'h1;
		{kstb, pstb, kcode, pval, cond, pwr, mismatches, checks} = '0;
		psel = MSR_PNL_CUR;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		wait_n(1);
		chk("ramp rate", 32'(rate), 32'(MSR_RATE_RST));
		rdc(MSR_ADR_KEY, 32'h0000_0001);
		rdc(MSR_ADR_KEY, 32'h0000_0000);
		key(7'h2A);
		rdc(MSR_ADR_KEY, 32'h0000_002A);
		key(7'h07);
		key(7'h09);
		rdc(MSR_ADR_KEY, 32'h0000_0009);
		wr(32'h30, 32'hFFFF_FFFF);
		rdc(8'h30, 32'h0000_0000);
		wr(MSR_ADR_LIM_CUR, 32'h000A_B249);
		rdc(MSR_ADR_LIM_CUR, 32'(MSR_CUR_MAX));
		wr(MSR_ADR_LIM_RATE, 32'h0000_0000);
		rdc(MSR_ADR_LIM_RATE, 32'(MSR_RATE_MAX));
		wr(MSR_ADR_LIM_RATE, 32'h0007_A121);
		rdc(MSR_ADR_LIM_RATE, 32'(MSR_RATE_MAX));
		wr(MSR_ADR_RATE, 32'h0000_0000);
		rdc(MSR_ADR_RATE, 32'(MSR_RATE_RST));
		wr(MSR_ADR_LIM_RATE, 32'h0000_1000);
		rdc(MSR_ADR_RATE, 32'h0000_1000);
		wr(MSR_ADR_RATE, 32'h0000_5000);
		rdc(MSR_ADR_RATE, 32'h0000_1000);
		chk("ramp rate", 32'(rate), 32'h0000_1000);
		wr(MSR_ADR_LIM_RATE, 32'(MSR_RATE_MAX));
		wr(MSR_ADR_RATE, 32'h0000_0001);
		rdc(MSR_ADR_RATE, 32'h0000_0001);
		pnl(MSR_PNL_RATE, 20'h0_0200, 1'h0);
		chk("ramp rate", 32'(rate), 32'h0000_0200);
		pnl(MSR_PNL_CUR, 20'h0_0100, 1'h0);
		chk("setpoint", 32'(cur), 32'h0000_0100);
		wr(MSR_ADR_LIM_CUR, 32'h0000_0080);
		wait_n(1);
		chk("setpoint", 32'(cur), 32'h0000_0080);
		rdc(MSR_ADR_CUR_SET, 32'h0000_0080);
		wr(MSR_ADR_LIM_CUR, 32'(MSR_CUR_MAX));
		for (int s = 0; s < 3; s++) begin
			wr(MSR_ADR_LOCK, 32'h03E7_0000 | 32'(s));
			rdc(MSR_ADR_LOCK, 32'h03E7_0000 | 32'(s));
			pnl(MSR_PNL_LIM_CUR, MSR_CUR_MAX, s != 0);
			pnl(MSR_PNL_CUR, 20'h0_0000, s == 1);
		end
		wr(MSR_ADR_LOCK, 32'h03E8_0001);
		rdc(MSR_ADR_LOCK, 32'h03E7_0002);
		wr(MSR_ADR_LOCK, 32'h0000_0000);
		for (int m = 0; m < 4; m++) begin
			wr(MSR_ADR_WATER, 32'(m));
			rdc(MSR_ADR_WATER, 32'(m));
			wait_n(3);
			chk("valve", 32'(valve), 32'(m == 1));
		end
		wr(MSR_ADR_WATER, 32'h0000_0002);
		pwr <= 16'h0064;
		wait_n(3);
		chk("valve", 32'(valve), 32'h0000_0001);
		pwr <= 16'h0040;
		wait_n(3);
		chk("valve", 32'(valve), 32'h0000_0001);
		pwr <= 16'h0032;
		wait_n(3);
		chk("valve", 32'(valve), 32'h0000_0000);
		for (int m = 0; m < 3; m++) begin
			wr(MSR_ADR_IFACE, 32'(m));
			wait_n(2);
			chk("remote", 32'(remote), 32'(m != 0));
			chk("lockout", 32'(lockout), 32'(m == 2));
		end
		pnl(MSR_PNL_CUR, 20'h0_0000, 1'h1);
		wr(MSR_ADR_IFACE, 32'h0000_0000);
		cond <= 8'h05;
		wait_n(5);
		rdc(MSR_ADR_OP_COND, 32'h0000_0005);
		cond <= 8'h00;
		wait_n(5);
		rdc(MSR_ADR_OP_COND, 32'h0000_0000);
		rdc(MSR_ADR_OP_EVENT, 32'h0000_0005);
		rdc(MSR_ADR_OP_EVENT, 32'h0000_0000);
		wr(MSR_ADR_OP_MASK, 32'h0000_0004);
		rdc(MSR_ADR_OP_MASK, 32'h0000_0004);
		cond <= 8'h04;
		wait_n(5);
		cond <= 8'h00;
		wait_n(5);
		chk("summary", 32'(summary), 32'h0000_0001);
		wr(MSR_ADR_OP_MASK, 32'h0000_0001);
		wait_n(2);
		chk("summary", 32'(summary), 32'h0000_0000);
		rdc(MSR_ADR_OP_EVENT, 32'h0000_0004);
		end_sim();
	end

	// Cut a hang short.
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		end_sim();
	end
endmodule

`default_nettype wire
